// ==== siro_consts.svh ====
// offsets, field positions and reset values for the stage routing and offset registers
`ifndef SIRO_CONSTS_SVH
`define SIRO_CONSTS_SVH
`define SIRO_NUM_STAGES       12
`define SIRO_STAGE_BASE_IDX   12'h080
`define SIRO_STAGE_STRIDE     12'h008
`define SIRO_HIGH_ROUTE_IDX   12'h001
`define SIRO_OFFSET_IDX       12'h002
`define SIRO_ROUTE_INPUT7     0
`define SIRO_ROUTE_INPUT8     2
`define SIRO_ROUTE_INPUT9     4
`define SIRO_ROUTE_INPUT10    6
`define SIRO_ROUTE_INPUT11    8
`define SIRO_ROUTE_INPUT12    10
`define SIRO_MEAS_TYPE_LSB    12
`define SIRO_MINUS_GATE_BIT   14
`define SIRO_PLUS_GATE_BIT    15
`define SIRO_MINUS_MAG_LSB    0
`define SIRO_MINUS_STEER_BIT  7
`define SIRO_PLUS_MAG_LSB     8
`define SIRO_PLUS_STEER_BIT   15
`define SIRO_REG_RESET        16'h0000
`define SIRO_RESP_OKAY        2'h0
`define SIRO_RESP_SLVERR      2'h2
`endif

// ==== siro_pkg.sv ====
// types for the stage routing and offset registers
package siro_pkg;
  typedef enum logic [1:0] {
    SIRO_ROUTE_OPEN,
    SIRO_ROUTE_MINUS,
    SIRO_ROUTE_PLUS,
    SIRO_ROUTE_BIAS
  } siro_route_t;
  typedef enum logic [1:0] {
    SIRO_MEAS_RESERVED,
    SIRO_MEAS_SINGLE_PLUS,
    SIRO_MEAS_SINGLE_MINUS,
    SIRO_MEAS_DIFF
  } siro_meas_t;
endpackage

// ==== siro_stage_regs.sv ====
// per-stage routing and front-end offset register bank behind an AXI4-Lite slave
//
// Operation
// - input 7 routing at bits 1:0: open, minus, plus, bias.
// - input 8 routing at bits 3:2, same four-way coding.
// - input 9 routing at bits 5:4, same four-way coding.
// - input 10 routing at bits 7:6, same four-way coding.
// - input 11 routing at bits 9:8, same four-way coding.
// - input 12 routing at bits 11:10, same four-way coding.
// - bits 13:12 choose single-ended plus, single-ended minus or differential.
// - high routing bit 14 set removes the minus front-end offset.
// - high routing bit 15 set removes the plus front-end offset.
// - minus offset magnitude, offset bits 5:0, 0.32 pF per count.
// - offset bit 7 moves the minus offset onto the plus input.
// - plus offset magnitude, offset bits 13:8, 0.32 pF per count.
// - offset bit 15 moves the plus offset onto the minus input.
// - twelve stages each hold their own routing and offset copy.
// - high routing one word above low, offset above that; stages eight apart.
//
// Our own choices: the address map and the AXI4-Lite register port.
`include "siro_consts.svh"
module siro_stage_regs (
  input  wire logic        core_clk,                  // 200 MHz clock
  input  wire logic        rst,                       // async reset, active high
  input  wire logic [13:0] s_axi_awaddr,              // write byte address
  input  wire logic        s_axi_awvalid,             // write address valid
  output logic             s_axi_awready,             // write address ready
  input  wire logic [31:0] s_axi_wdata,               // write data
  input  wire logic [3:0]  s_axi_wstrb,               // write byte strobes
  input  wire logic        s_axi_wvalid,              // write data valid
  output logic             s_axi_wready,              // write data ready
  output logic [1:0]       s_axi_bresp,               // write response
  output logic             s_axi_bvalid,              // write response valid
  input  wire logic        s_axi_bready,              // write response ready
  input  wire logic [13:0] s_axi_araddr,              // read byte address
  input  wire logic        s_axi_arvalid,             // read address valid
  output logic             s_axi_arready,             // read address ready
  output logic [31:0]      s_axi_rdata,               // read data
  output logic [1:0]       s_axi_rresp,               // read response
  output logic             s_axi_rvalid,              // read data valid
  input  wire logic        s_axi_rready,              // read data ready
  input  wire logic [3:0]  active_stage,              // stage the sequencer converts
  output logic [1:0]       route_field_input7,        // input 7 routing
  output logic [1:0]       route_field_input8,        // input 8 routing
  output logic [1:0]       route_field_input9,        // input 9 routing
  output logic [1:0]       route_field_input10,       // input 10 routing
  output logic [1:0]       route_field_input11,       // input 11 routing
  output logic [1:0]       route_field_input12,       // input 12 routing
  output logic [1:0]       measurement_type_select,   // measurement type
  output logic             minus_offset_apply,        // minus offset applied
  output logic             plus_offset_apply,         // plus offset applied
  output logic [5:0]       minus_offset_magnitude,    // minus offset counts
  output logic             minus_offset_steer,        // minus offset on plus input
  output logic [5:0]       plus_offset_magnitude,     // plus offset counts
  output logic             plus_offset_steer,         // plus offset on minus input
  output logic [5:0]       minus_offset_to_minus_in,  // counts added at converter minus input
  output logic [5:0]       minus_offset_to_plus_in,   // counts added at converter plus input
  output logic [5:0]       plus_offset_to_plus_in,    // counts added at converter plus input
  output logic [5:0]       plus_offset_to_minus_in    // counts added at converter minus input
);

  // word decode: returns stage index in [3:0], register select in [5:4], hit in [6]
  function automatic logic [6:0] siro_decode(input logic [13:0] byte_addr);
    logic [11:0] word;
    logic [11:0] rel;
    logic [3:0]  stage;
    logic [2:0]  sel;
    word = byte_addr[13:2];
    rel = word - `SIRO_STAGE_BASE_IDX;
    stage = rel[6:3];
    sel = rel[2:0];
    siro_decode = 7'h00;
    if (word < `SIRO_STAGE_BASE_IDX)
      siro_decode = 7'h00;
    else if (rel[11:7] != 5'h00 || stage >= 4'(`SIRO_NUM_STAGES))
      siro_decode = 7'h00;
    else if (sel == 3'(`SIRO_HIGH_ROUTE_IDX))
      siro_decode = {1'b1, 2'h1, stage};
    else if (sel == 3'(`SIRO_OFFSET_IDX))
      siro_decode = {1'b1, 2'h2, stage};
  endfunction

  // byte-lane merge into a 16-bit register; strobes 3:2 have no lane to land in
  function automatic logic [15:0] siro_merge(input logic [15:0] old_val, input logic [15:0] new_val,
                                             input logic [1:0] strb);
    logic [15:0] mask;
    mask = {{8{strb[1]}}, {8{strb[0]}}};
    siro_merge = (old_val & ~mask) | (new_val & mask);
  endfunction

  // offset counts seen at one converter input: nothing when removed or steered to the other input
  function automatic logic [5:0] siro_steer_count(input logic on, input logic to_here, input logic [5:0] mag);
    siro_steer_count = 6'h00;
    if (on && to_here)
      siro_steer_count = mag;
  endfunction

  // low routing words (inputs 0..6) live in another block, so word 0 of a stage is unmapped here
  logic [15:0] high_route [`SIRO_NUM_STAGES];
  logic [15:0] fe_offset  [`SIRO_NUM_STAGES];
  logic [15:0] next_high_route [`SIRO_NUM_STAGES];
  logic [15:0] next_fe_offset  [`SIRO_NUM_STAGES];

  logic        aw_held, next_aw_held;
  logic [13:0] aw_addr, next_aw_addr;
  logic        w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [6:0]  wdec, rdec;
  logic        do_write;

  // a waiting response blocks new requests, so one write and one read at most are in flight
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_high_route = high_route;
    next_fe_offset = fe_offset;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held;
    wdec = siro_decode(aw_addr);
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wdec[6] ? `SIRO_RESP_OKAY : `SIRO_RESP_SLVERR;
      // unused bits 6 and 14 of the offset word are stored as written
      if (wdec[6] && wdec[5:4] == 2'h1)
        next_high_route[wdec[3:0]] = siro_merge(high_route[wdec[3:0]], w_data[15:0], w_strb[1:0]);
      else if (wdec[6] && wdec[5:4] == 2'h2)
        next_fe_offset[wdec[3:0]] = siro_merge(fe_offset[wdec[3:0]], w_data[15:0], w_strb[1:0]);
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
  end

  always_comb
  begin
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    rdec = siro_decode(s_axi_araddr);
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = rdec[6] ? `SIRO_RESP_OKAY : `SIRO_RESP_SLVERR;
      if (rdec[6] && rdec[5:4] == 2'h1)
        next_rdata = {16'h0000, high_route[rdec[3:0]]};
      else if (rdec[6] && rdec[5:4] == 2'h2)
        next_rdata = {16'h0000, fe_offset[rdec[3:0]]};
      else
        next_rdata = 32'h0000_0000;
    end
    else if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  // write group: request holding, response and the register arrays
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= 14'h0000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `SIRO_RESP_OKAY;
      for (int i = 0; i < `SIRO_NUM_STAGES; i++)
      begin
        high_route[i] <= `SIRO_REG_RESET;
        fe_offset[i] <= `SIRO_REG_RESET;
      end
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      high_route <= next_high_route;
      fe_offset <= next_fe_offset;
    end
  end

  // read group: data captured when the address is taken, held until rready
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rresp <= `SIRO_RESP_OKAY;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // stage selection for the analog side; out-of-range stage reads as stage 0
  logic [15:0] sel_route, sel_offset;
  logic [15:0] next_sel_route, next_sel_offset;
  logic        minus_on, plus_on;

  always_comb
  begin
    next_sel_route = high_route[0];
    next_sel_offset = fe_offset[0];
    if (active_stage < 4'(`SIRO_NUM_STAGES))
    begin
      next_sel_route = high_route[active_stage];
      next_sel_offset = fe_offset[active_stage];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_route <= `SIRO_REG_RESET;
      sel_offset <= `SIRO_REG_RESET;
    end
    else
    begin
      sel_route <= next_sel_route;
      sel_offset <= next_sel_offset;
    end
  end

  // codes kept as the package enums so a waveform names open, minus, plus, bias and the measurement kind
  siro_pkg::siro_route_t route_code [6];
  siro_pkg::siro_meas_t  meas_code;

  always_comb
  begin
    route_code[0] = siro_pkg::siro_route_t'(sel_route[`SIRO_ROUTE_INPUT7 +: 2]);
    route_code[1] = siro_pkg::siro_route_t'(sel_route[`SIRO_ROUTE_INPUT8 +: 2]);
    route_code[2] = siro_pkg::siro_route_t'(sel_route[`SIRO_ROUTE_INPUT9 +: 2]);
    route_code[3] = siro_pkg::siro_route_t'(sel_route[`SIRO_ROUTE_INPUT10 +: 2]);
    route_code[4] = siro_pkg::siro_route_t'(sel_route[`SIRO_ROUTE_INPUT11 +: 2]);
    route_code[5] = siro_pkg::siro_route_t'(sel_route[`SIRO_ROUTE_INPUT12 +: 2]);
    meas_code = siro_pkg::siro_meas_t'(sel_route[`SIRO_MEAS_TYPE_LSB +: 2]);
  end

  assign route_field_input7 = route_code[0];
  assign route_field_input8 = route_code[1];
  assign route_field_input9 = route_code[2];
  assign route_field_input10 = route_code[3];
  assign route_field_input11 = route_code[4];
  assign route_field_input12 = route_code[5];
  assign measurement_type_select = meas_code;
  assign minus_on = !sel_route[`SIRO_MINUS_GATE_BIT];
  assign plus_on = !sel_route[`SIRO_PLUS_GATE_BIT];
  assign minus_offset_apply = minus_on;
  assign plus_offset_apply = plus_on;
  assign minus_offset_magnitude = sel_offset[`SIRO_MINUS_MAG_LSB +: 6];
  assign minus_offset_steer = sel_offset[`SIRO_MINUS_STEER_BIT];
  assign plus_offset_magnitude = sel_offset[`SIRO_PLUS_MAG_LSB +: 6];
  assign plus_offset_steer = sel_offset[`SIRO_PLUS_STEER_BIT];

  // gated and steered offset counts, zero where removed or steered away
  assign minus_offset_to_minus_in = siro_steer_count(minus_on, !minus_offset_steer, minus_offset_magnitude);
  assign minus_offset_to_plus_in = siro_steer_count(minus_on, minus_offset_steer, minus_offset_magnitude);
  assign plus_offset_to_plus_in = siro_steer_count(plus_on, !plus_offset_steer, plus_offset_magnitude);
  assign plus_offset_to_minus_in = siro_steer_count(plus_on, plus_offset_steer, plus_offset_magnitude);

endmodule

// ==== siro_stage_regs_assertions.sv ====
// concurrent checks on the stage register bank bus handshakes and offset steering
module siro_assertions (
  input wire logic       core_clk,                 // clock
  input wire logic       rst,                      // async reset
  input wire logic       s_axi_awvalid,            // aw valid
  input wire logic       s_axi_awready,            // aw ready
  input wire logic       s_axi_wvalid,             // w valid
  input wire logic       s_axi_wready,             // w ready
  input wire logic [1:0] s_axi_bresp,              // b code
  input wire logic       s_axi_bvalid,             // b valid
  input wire logic       s_axi_bready,             // b ready
  input wire logic       s_axi_arvalid,            // ar valid
  input wire logic       s_axi_arready,            // ar ready
  input wire logic [31:0] s_axi_rdata,             // r data
  input wire logic       s_axi_rvalid,             // r valid
  input wire logic       s_axi_rready,             // r ready
  input wire logic       minus_offset_apply,       // minus on
  input wire logic       plus_offset_apply,        // plus on
  input wire logic [5:0] minus_offset_magnitude,   // minus counts
  input wire logic       minus_offset_steer,       // minus steer
  input wire logic [5:0] plus_offset_magnitude,    // plus counts
  input wire logic       plus_offset_steer,        // plus steer
  input wire logic [5:0] minus_offset_to_minus_in, // minus at minus
  input wire logic [5:0] minus_offset_to_plus_in,  // minus at plus
  input wire logic [5:0] plus_offset_to_minus_in   // plus at minus
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  property p_wr_answer; s_wr_take |-> ##[1:3] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_b_hold; s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_mm; minus_offset_to_minus_in ==
    ((minus_offset_apply && !minus_offset_steer) ? minus_offset_magnitude : 6'h00); endproperty
  a_mm: assert property (p_mm) else $error("minus offset at minus wrong");
  property p_mp; minus_offset_to_plus_in ==
    ((minus_offset_apply && minus_offset_steer) ? minus_offset_magnitude : 6'h00); endproperty
  a_mp: assert property (p_mp) else $error("minus offset at plus wrong");
  property p_pm; plus_offset_to_minus_in ==
    ((plus_offset_apply && plus_offset_steer) ? plus_offset_magnitude : 6'h00); endproperty
  a_pm: assert property (p_pm) else $error("plus offset at minus wrong");
endmodule

// ==== tb_siro_stage_regs.sv ====
// self-checking bench for the stage routing and offset register bank
`include "siro_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch at %0t: %h vs %h", $time, g, e); end end
module tb_siro_stage_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h0, active_stage = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic minus_offset_apply, plus_offset_apply, minus_offset_steer, plus_offset_steer;
  logic [1:0] s_axi_bresp, s_axi_rresp, measurement_type_select, r, route_field_input7, route_field_input8;
  logic [1:0] route_field_input9, route_field_input10, route_field_input11, route_field_input12;
  logic [5:0] minus_offset_magnitude, plus_offset_magnitude, minus_offset_to_minus_in, minus_offset_to_plus_in;
  logic [5:0] plus_offset_to_plus_in, plus_offset_to_minus_in;
  int n_fail = 0, num_checks = 0;
  int lag = 0;
  always #2.5 core_clk = ~core_clk;
  siro_stage_regs u_dut (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .active_stage(active_stage),
    .route_field_input7(route_field_input7), .route_field_input8(route_field_input8),
    .route_field_input9(route_field_input9), .route_field_input10(route_field_input10),
    .route_field_input11(route_field_input11), .route_field_input12(route_field_input12),
    .measurement_type_select(measurement_type_select),
    .minus_offset_apply(minus_offset_apply), .plus_offset_apply(plus_offset_apply),
    .minus_offset_magnitude(minus_offset_magnitude), .minus_offset_steer(minus_offset_steer),
    .plus_offset_magnitude(plus_offset_magnitude), .plus_offset_steer(plus_offset_steer),
    .minus_offset_to_minus_in(minus_offset_to_minus_in), .minus_offset_to_plus_in(minus_offset_to_plus_in),
    .plus_offset_to_plus_in(plus_offset_to_plus_in), .plus_offset_to_minus_in(plus_offset_to_minus_in)
  );
  // exactly one input per stage on the minus side, so every measurement code 01..11 is legal
  function automatic logic [15:0] hv(input int s);
    logic [15:0] v;
    v = {s[1], s[0], 2'((s % 3) + 1), 12'h000};
    for (int i = 0; i < 6; i++)
      v[2*i +: 2] = (i == s % 6) ? 2'h1 : ((s + i) % 3 == 0 ? 2'h0 : ((s + i) % 3 == 1 ? 2'h2 : 2'h3));
    return v;
  endfunction
  function automatic logic [15:0] ov(input int s);
    return {s[2], 1'b0, 6'(63 - s), s[1], 1'b0, 6'(5 * s + 1)};
  endfunction
  function automatic logic [13:0] ad(input int s, input int sel);
    return 14'(4 * (`SIRO_STAGE_BASE_IDX + `SIRO_STAGE_STRIDE * s + sel));
  endfunction
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ready sampled at the negedge: it only moves on rising edges
  task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [3:0] st);
    logic ta, tw, b;
    b = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    // ready is held back until lag cycles after the request, past the answer, so the response must hold meanwhile
    s_axi_bready <= (lag == 0);
    for (int i = 0; i < 50 && !b; i++)
    begin
      @(negedge core_clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (!b && i + 1 >= lag) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (!b) begin n_fail++; summarize(); end
  endtask
  task automatic rd(input logic [13:0] a);
    logic ta, b;
    b = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    for (int i = 0; i < 50 && !b; i++)
    begin
      @(negedge core_clk);
      ta = s_axi_arready && s_axi_arvalid;
      b = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (!b && i + 1 >= lag) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (!b) begin n_fail++; summarize(); end
  endtask
  task automatic fields(input logic [15:0] h, input logic [15:0] o, input logic [3:0] as);
    logic [11:0] rt;
    @(posedge core_clk);
    active_stage <= as;
    repeat (3) @(negedge core_clk);
    rt = {route_field_input12, route_field_input11, route_field_input10, route_field_input9, route_field_input8,
      route_field_input7};
    `CHK(rt, h[11:0])
    `CHK(measurement_type_select, h[13:12])
    `CHK(({plus_offset_apply, minus_offset_apply}), ~h[15:14])
    `CHK(({minus_offset_steer, minus_offset_magnitude}), ({o[7], o[5:0]}))
    `CHK(({plus_offset_steer, plus_offset_magnitude}), ({o[15], o[13:8]}))
    `CHK(plus_offset_to_plus_in, ((!h[15] && !o[15]) ? o[13:8] : 6'h00))
    `CHK(plus_offset_to_minus_in, ((!h[15] && o[15]) ? o[13:8] : 6'h00))
    `CHK(minus_offset_to_minus_in, ((!h[14] && !o[7]) ? o[5:0] : 6'h00))
    `CHK(minus_offset_to_plus_in, ((!h[14] && o[7]) ? o[5:0] : 6'h00))
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int s = 0; s < 12; s++)
    begin
      wr(ad(s, 1), {16'ha5a5, hv(s)}, 4'hf);
      `CHK(r, `SIRO_RESP_OKAY)
      wr(ad(s, 2), {16'h5a5a, ov(s)}, 4'hf);
      `CHK(r, `SIRO_RESP_OKAY)
    end
    for (int s = 0; s < 12; s++)
    begin
      rd(ad(s, 1));
      `CHK(d, ({16'h0000, hv(s)}))
      rd(ad(s, 2));
      `CHK(d, ({16'h0000, ov(s)}))
      fields(hv(s), ov(s), 4'(s));
    end
    fields(hv(0), ov(0), 4'hc);
    wr(ad(3, 2), 32'h0, 4'h1);
    rd(ad(3, 2));
    `CHK(d, ({16'h0000, ov(3) & 16'hff00}))
    for (int k = 0; k < 9; k++)
    begin
      if (k != 1 && k != 2)
      begin
        wr(ad(k == 8 ? 12 : 0, k == 8 ? 1 : k), 32'hffff, 4'hf);
        `CHK(r, `SIRO_RESP_SLVERR)
        rd(ad(k == 8 ? 12 : 0, k == 8 ? 1 : k));
        `CHK(({r, d}), ({`SIRO_RESP_SLVERR, 32'h0}))
      end
    end
    rd(ad(0, 1));
    `CHK(d, ({16'h0000, hv(0)}))
    wr(ad(5, 1), 32'h0000_1ffe, 4'hf);
    `CHK(r, `SIRO_RESP_OKAY)
    fields(16'h1ffe, ov(5), 4'h5);
    lag = 3;
    wr(ad(7, 2), {16'h0000, ov(7)}, 4'hf);
    `CHK(r, `SIRO_RESP_OKAY)
    rd(ad(7, 2));
    `CHK(({r, d}), ({`SIRO_RESP_OKAY, 16'h0000, ov(7)}))
    lag = 0;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(ad(0, 1));
    `CHK(({r, d}), ({`SIRO_RESP_OKAY, 16'h0000, `SIRO_REG_RESET}))
    fields(`SIRO_REG_RESET, `SIRO_REG_RESET, 4'h0);
    summarize();
  end
endmodule
bind siro_stage_regs siro_assertions u_chk (
  .core_clk(core_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .minus_offset_apply(minus_offset_apply), .plus_offset_apply(plus_offset_apply),
  .minus_offset_magnitude(minus_offset_magnitude), .minus_offset_steer(minus_offset_steer),
  .plus_offset_magnitude(plus_offset_magnitude), .plus_offset_steer(plus_offset_steer),
  .minus_offset_to_minus_in(minus_offset_to_minus_in), .minus_offset_to_plus_in(minus_offset_to_plus_in),
  .plus_offset_to_minus_in(plus_offset_to_minus_in)
);
